/* qdr_host.sv */
// host controller model framing read commands
`timescale 1ns/100ps
module qdr_host (
   input  wire logic       clk,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe,
   output      logic       cs_n,
   output      logic       sck,
   output      logic [3:0] io_in
);
   logic [3:0] drv = 4'h0;
   logic       hoe = 1'b0;
   logic       flt = 1'b0;
   logic [7:0] got [0:7];
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
   end
   // released lines wander so a stale level never passes
   always @(posedge clk) flt <= ~flt;
   assign io_in = (io_oe & io_out) | (~io_oe & (hoe ? drv : {4{flt}}));
   task automatic unit(input logic [3:0] v);
      sck = 1'b0;
      drv = v;
      #100 sck = 1'b1;
      #100;
   endtask
   task automatic frame(input logic [7:0] cmd, input bit use_cmd, input int abits, input bit dual,
                        input logic [31:0] a, input logic [7:0] mode, input int ndum, input int nun);
      logic [7:0] sh;
      int w;
      int upb;
      w = dual ? 2 : 1;
      // quad bytes are two nibbles, dual bytes four pairs
      upb = dual ? 4 : 2;
      @(negedge clk);
      cs_n = 1'b0;
      hoe = 1'b1;
      #100;
      if (use_cmd) for (int i = 7; i >= 0; i--) unit({3'h0, cmd[i]});
      for (int i = abits - w; i >= 0; i -= w) unit(dual ? {2'h0, a[i+1], a[i]} : {3'h0, a[i]});
      if (dual) begin
         unit({2'h0, mode[7:6]});
         unit({2'h0, mode[5:4]});
         hoe = 1'b0;
         unit(4'h0);
         unit(4'h0);
      end
      hoe = 1'b0;
      for (int i = 0; i < ndum; i++) unit(4'h0);
      for (int j = 0; j < nun; j++) begin
         sck = 1'b0;
         #100 sck = 1'b1;
         #99 sh = dual ? {sh[5:0], io_in[1:0]} : {sh[3:0], io_in};
         if (j % upb == upb - 1) got[j / upb] = sh;
         #1;
      end
      sck = 1'b0;
      #100 cs_n = 1'b1;
      #100;
   endtask
endmodule

/* qdr_map.svh */
// offsets, codes and counts for the quad-output / dual-io read front end
`ifndef QDR_MAP_SVH
`define QDR_MAP_SVH
`define QDR_CMD_QUAD        8'h6b
`define QDR_CMD_QUAD_WIDE   8'h6c
`define QDR_CMD_DUAL        8'hbb
`define QDR_CMD_DUAL_WIDE   8'hbc
`define QDR_CMD_MODE_RESET  8'hff
`define QDR_RESET_RISES     4'h8
`define QDR_MODE_CONT       4'ha
`define QDR_CMD_LAST        6'h07
`define QDR_QUAD_LAST_WIDE  6'h1f
`define QDR_QUAD_LAST_NARR  6'h17
`define QDR_DUAL_LAST_WIDE  6'h0f
`define QDR_DUAL_LAST_NARR  6'h0b
`define QDR_MODE_LAST       6'h03
`define QDR_ADDR3_MASK      32'h00ffffff
`define QDR_OE_QUAD         4'hf
`define QDR_OE_DUAL         4'h3
`endif

/* qdr_pkg.sv */
// types for the quad-output / dual-io read front end
package qdr_pkg;

   typedef enum logic [6:0] {
      S_IDLE   = 7'b0000001,
      S_CMD    = 7'b0000010,
      S_ADDR   = 7'b0000100,
      S_MODE   = 7'b0001000,
      S_DUMMY  = 7'b0010000,
      S_DATA   = 7'b0100000,
      S_IGNORE = 7'b1000000
   } qdr_state_e;

   typedef struct packed {
      qdr_state_e  st;
      logic        sck_m;
      logic        sck_s;
      logic        sck_d;
      logic        cs_m;
      logic        cs_s;
      logic        cs_d;
      logic [3:0]  io_m;
      logic [3:0]  io_s;
      logic [7:0]  cmd;
      logic        quad;
      logic        wide;
      logic [31:0] addr;
      logic [5:0]  cnt;
      logic [1:0]  mode_hi;
      logic        mode_keep;
      logic        mode_seen;
      logic        cont;
      logic [1:0]  pos;
      logic [7:0]  sh;
      logic [7:0]  rst_sh;
      logic [3:0]  rises;
      logic [3:0]  out;
      logic [3:0]  oe;
   } qdr_regs_s;

endpackage

/* qdr_read.sv */
// serial flash read front end: quad-output read and dual-io read with continuous mode
`timescale 1ns/100ps
`include "qdr_map.svh"

module qdr_read
   import qdr_pkg::*;
#(
   parameter int ARRAY_AW = 24
) (
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                CS_N,
   input  wire logic                SCK,
   input  wire logic [3:0]          IO_IN,
   output      logic [3:0]          IO_OUT,
   output      logic [3:0]          IO_OE,
   input  wire logic                ADDR_LEN_BIT,
   input  wire logic [3:0]          LATENCY_CODE,
   output      logic [ARRAY_AW-1:0] ARRAY_ADDR,
   input  wire logic [7:0]          ARRAY_DATA,
   output      logic                CONT_MODE
);

   localparam logic [31:0] AMASK = 32'((64'h1 << ARRAY_AW) - 64'h1);

   localparam qdr_regs_s REGS_RST = '{
      st:      S_IDLE,
      cs_m:    1'b1,
      cs_s:    1'b1,
      cs_d:    1'b1,
      default: '0
   };

   qdr_regs_s r;
   qdr_regs_s n;

   logic        rise;
   logic        fall;
   logic        cs_rise;
   logic        emit;
   logic [7:0]  cmd_new;
   logic [31:0] addr_new;
   logic [5:0]  addr_last;
   logic [7:0]  cur;
   logic [5:0]  latency;

   // edges come from the second and third stages, never the first
   assign rise    = r.sck_s & ~r.sck_d;
   assign fall    = ~r.sck_s & r.sck_d;
   assign cs_rise = r.cs_s & ~r.cs_d;
   assign latency = {2'b00, LATENCY_CODE};

   always_comb begin
      n        = r;
      emit     = 1'b0;
      cmd_new  = {r.cmd[6:0], r.io_s[0]};
      cur      = (r.pos == 2'b00) ? ARRAY_DATA : r.sh;
      addr_new = r.quad ? {r.addr[30:0], r.io_s[0]}
                        : {r.addr[29:0], r.io_s[1], r.io_s[0]};
      if (r.quad) begin
         addr_last = r.wide ? `QDR_QUAD_LAST_WIDE : `QDR_QUAD_LAST_NARR;
      end else begin
         addr_last = r.wide ? `QDR_DUAL_LAST_WIDE : `QDR_DUAL_LAST_NARR;
      end

      n.sck_m = SCK;
      n.sck_s = r.sck_m;
      n.sck_d = r.sck_s;
      n.cs_m  = CS_N;
      n.cs_s  = r.cs_m;
      n.cs_d  = r.cs_s;
      n.io_m  = IO_IN;
      n.io_s  = r.io_m;

      if (r.cs_s) begin
         // deselected: any read in progress ends here
         n.st    = S_IDLE;
         n.oe    = 4'h0;
         n.out   = 4'h0;
         n.rises = 4'h0;
         n.pos   = 2'b00;
         if (cs_rise) begin
            // continuation is only committed at the frame end
            if (r.mode_seen) begin
               n.cont = r.mode_keep;
            end
            if (r.rises == `QDR_RESET_RISES && r.rst_sh == `QDR_CMD_MODE_RESET) begin
               n.cont = 1'b0;
            end
            n.mode_seen = 1'b0;
         end
      end else begin
         // io0 history for spotting the mode reset in any state
         if (rise) begin
            // own history, the instruction register only shifts in the command phase and is cleared in idle
            n.rst_sh = {r.rst_sh[6:0], r.io_s[0]};
            if (r.rises != 4'hf) begin
               n.rises = r.rises + 4'h1;
            end
         end

         unique case (r.st)
            S_IDLE: begin
               n.cnt  = 6'h00;
               n.addr = 32'h0;
               n.cmd  = 8'h00;
               if (r.cont) begin
                  // continuous: address comes first, same width as before
                  n.quad = 1'b0;
                  n.st   = S_ADDR;
               end else begin
                  n.st = S_CMD;
               end
            end

            S_CMD: begin
               if (rise) begin
                  n.cmd = cmd_new;
                  n.cnt = r.cnt + 6'h01;
                  if (r.cnt == `QDR_CMD_LAST) begin
                     n.cnt = 6'h00;
                     n.st  = S_ADDR;
                     unique case (cmd_new)
                        `QDR_CMD_QUAD: begin
                           n.quad = 1'b1;
                           n.wide = ADDR_LEN_BIT;
                        end
                        `QDR_CMD_QUAD_WIDE: begin
                           n.quad = 1'b1;
                           n.wide = 1'b1;
                        end
                        `QDR_CMD_DUAL: begin
                           n.quad = 1'b0;
                           n.wide = ADDR_LEN_BIT;
                        end
                        `QDR_CMD_DUAL_WIDE: begin
                           n.quad = 1'b0;
                           n.wide = 1'b1;
                        end
                        default: begin
                           // other commands, mode reset among them, are not served here
                           n.st = S_IGNORE;
                        end
                     endcase
                  end
               end
            end

            S_ADDR: begin
               if (rise) begin
                  n.addr = addr_new;
                  n.cnt  = r.cnt + 6'h01;
                  if (r.cnt == addr_last) begin
                     if (!r.wide) begin
                        n.addr = addr_new & `QDR_ADDR3_MASK;
                     end
                     n.addr = n.addr & AMASK;
                     if (r.quad) begin
                        n.cnt = latency;
                        n.st  = S_DUMMY;
                     end else begin
                        n.cnt = 6'h00;
                        n.st  = S_MODE;
                     end
                  end
               end
            end

            S_MODE: begin
               if (rise) begin
                  n.cnt = r.cnt + 6'h01;
                  if (r.cnt == 6'h00) begin
                     n.mode_hi = {r.io_s[1], r.io_s[0]};
                  end
                  // lower nibble cycles only feed the io0 history, never the mode decode; the host may float them
                  if (r.cnt == 6'h01) begin
                     n.mode_keep = ({r.mode_hi, r.io_s[1], r.io_s[0]} == `QDR_MODE_CONT);
                     n.mode_seen = 1'b1;
                  end
                  if (r.cnt == `QDR_MODE_LAST) begin
                     n.cnt = latency;
                     n.st  = S_DUMMY;
                  end
               end
            end

            S_DUMMY: begin
               // only the io0 history samples the lines here, so a floating host is harmless
               if (fall) begin
                  if (r.cnt == 6'h00) begin
                     emit = 1'b1;
                     n.st = S_DATA;
                  end else begin
                     n.cnt = r.cnt - 6'h01;
                  end
               end
            end

            S_DATA: begin
               if (fall) begin
                  emit = 1'b1;
               end
            end

            S_IGNORE: begin
               n.oe = 4'h0;
            end
         endcase

         if (emit) begin
            // first fall of data doubles as the host's turn-around deadline
            if (r.quad) begin
               n.out = cur[7:4];
               n.oe  = `QDR_OE_QUAD;
               n.sh  = {cur[3:0], 4'h0};
            end else begin
               n.out = {2'b00, cur[7], cur[6]};
               n.oe  = `QDR_OE_DUAL;
               n.sh  = {cur[5:0], 2'b00};
            end
            n.pos = r.pos + 2'b01;
            if ((r.quad && r.pos == 2'b01) || r.pos == 2'b11) begin
               n.pos  = 2'b00;
               // next byte address, wrapping past the top of the array
               n.addr = (r.addr + 32'h1) & AMASK;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= REGS_RST;
      end else begin
         r <= n;
      end
   end

   assign IO_OUT     = r.out;
   assign IO_OE      = r.oe;
   assign ARRAY_ADDR = r.addr[ARRAY_AW-1:0];
   assign CONT_MODE  = r.cont;

endmodule

/* qdr_read_bench.sv */
// self-checking bench for the read front end
`timescale 1ns/100ps
module qdr_read_bench;
   localparam int AW = 16;
   logic          clk;
   logic          rst_n;
   logic          cs_n;
   logic          sck;
   logic          alen;
   logic [3:0]    io_in;
   logic [3:0]    io_out;
   logic [3:0]    io_oe;
   logic [3:0]    lat;
   logic [AW-1:0] a_addr;
   logic [7:0]    a_data;
   logic          cont;
   int            fails = 0;
   int            cmp_count = 0;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // array contents: a fixed function of the address
   assign a_data = a_addr[7:0] ^ 8'h3c;
   qdr_read #(.ARRAY_AW(AW)) dut_u (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck), .IO_IN(io_in),
      .IO_OUT(io_out), .IO_OE(io_oe), .ADDR_LEN_BIT(alen), .LATENCY_CODE(lat), .ARRAY_ADDR(a_addr),
      .ARRAY_DATA(a_data), .CONT_MODE(cont));
   qdr_host host_u (.clk(clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sck(sck), .io_in(io_in));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_run(input logic [AW-1:0] a, input int n);
      for (int i = 0; i < n; i++) check("read byte", host_u.got[i], 8'(AW'(a + i)) ^ 8'h3c);
   endtask
   task automatic check_cont(input logic exp);
      repeat (4) @(negedge clk);
      check("cont mode", {7'h0, cont}, {7'h0, exp});
   endtask
   task automatic t_quad;
      @(negedge clk) lat = 4'h0;
      host_u.frame(8'h6b, 1, 24, 0, 32'h0000fffe, 8'h0, 0, 6);
      check_run(16'hfffe, 3);
      @(negedge clk) lat = 4'h3;
      host_u.frame(8'h6c, 1, 32, 0, 32'hab001230, 8'h0, 3, 4);
      check_run(16'h1230, 2);
      @(negedge clk) alen = 1'b1;
      host_u.frame(8'h6b, 1, 32, 0, 32'h5a000777, 8'h0, 3, 2);
      check_run(16'h0777, 1);
      @(negedge clk) alen = 1'b0;
      $display("test quad done");
   endtask
   task automatic t_dual;
      @(negedge clk) lat = 4'h2;
      host_u.frame(8'hbb, 1, 24, 1, 32'h00000100, 8'ha5, 2, 8);
      check_run(16'h0100, 2);
      check_cont(1'b1);
      host_u.frame(8'h00, 0, 24, 1, 32'h00004321, 8'h5a, 2, 4);
      check_run(16'h4321, 1);
      check_cont(1'b0);
      host_u.frame(8'hbc, 1, 32, 1, 32'h77000042, 8'hac, 2, 4);
      check_run(16'h0042, 1);
      check_cont(1'b1);
      host_u.frame(8'hff, 1, 0, 0, 32'h0, 8'h0, 0, 0);
      check_cont(1'b0);
      $display("test dual done");
   endtask
   task automatic t_abort;
      @(negedge clk) lat = 4'h1;
      host_u.frame(8'h6b, 1, 24, 0, 32'h00000020, 8'h0, 1, 3);
      check_run(16'h0020, 1);
      check("oe after stop", {4'h0, io_oe}, 8'h00);
      $display("test abort done");
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // generous bound: eight frames of at most some 10 us each
   initial begin
      #400000;
      fails++;
      $display("ERROR watchdog expired");
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      alen = 1'b0;
      lat = 4'h0;
      repeat (4) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("oe after reset", {4'h0, io_oe}, 8'h00);
      t_quad();
      t_dual();
      t_abort();
      print_verdict();
   end
endmodule

/* qdr_read_sva.sv */
// port assertions for the read front end
`timescale 1ns/100ps
module qdr_read_sva #(
   parameter int ARRAY_AW = 24
) (
   input wire logic                CLK,
   input wire logic                RST_N,
   input wire logic                CS_N,
   input wire logic                SCK,
   input wire logic [3:0]          IO_OUT,
   input wire logic [3:0]          IO_OE,
   input wire logic [ARRAY_AW-1:0] ARRAY_ADDR,
   input wire logic [7:0]          ARRAY_DATA,
   input wire logic                CONT_MODE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_cs_up;
      $rose(CS_N) ##1 CS_N [*2];
   endsequence
   chk_oe_codes: assert property (IO_OE == 4'h0 || IO_OE == 4'hf || IO_OE == 4'h3)
      else $error("bad output enable");
   chk_dual_upper: assert property (IO_OE == 4'h3 |-> IO_OUT[3:2] == 2'h0)
      else $error("dual upper lines not zero");
   chk_quad_first: assert property ($rose(IO_OE == 4'hf) |-> IO_OUT == ARRAY_DATA[7:4])
      else $error("quad first nibble wrong");
   chk_dual_first: assert property ($rose(IO_OE == 4'h3) |-> IO_OUT[1:0] == ARRAY_DATA[7:6])
      else $error("dual first pair wrong");
   chk_fall_paced: assert property ($changed(IO_OUT) && IO_OE != 4'h0 |-> !$past(SCK, 3))
      else $error("data not launched by a fall");
   chk_addr_step: assert property ($changed(ARRAY_ADDR) && $past(IO_OE) != 4'h0
      |-> ARRAY_ADDR == ARRAY_AW'($past(ARRAY_ADDR) + 1))
      else $error("address not stepped by one");
   chk_oe_release: assert property (s_cs_up |-> ##[0:3] IO_OE == 4'h0)
      else $error("lines held after select rise");
   chk_cont_framed: assert property ($changed(CONT_MODE) |-> $past(CS_N, 2) && CS_N)
      else $error("continuous mode moved inside a frame");
endmodule
bind qdr_read qdr_read_sva #(.ARRAY_AW(ARRAY_AW)) chk_u (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK),
   .IO_OUT(IO_OUT), .IO_OE(IO_OE), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA), .CONT_MODE(CONT_MODE));
